// file: hdl/pps_pkg.sv
// package for the primary bus pin engine: widths, constants, pin and request carriers
// assumes one 50 MHz clock and an asynchronous active-low reset
package pps_pkg;

  localparam int AD_W     = 32;
  localparam int CMD_BE_W = 4;

  // dual address cycle command code on the command / byte-enable lines
  localparam logic [CMD_BE_W-1:0] CMD_DUAL_ADDRESS = 4'hd;

  // clocks after frame assertion to wait for device select before master abort
  localparam logic [2:0] DEVSEL_LIMIT = 3'h5;

  // parking values for the address/data and command lines
  localparam logic [AD_W-1:0]     PARK_AD     = 32'h0000_0000;
  localparam logic [CMD_BE_W-1:0] PARK_CMD_BE = 4'h0;

  // synchroniser stages for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [AD_W-1:0]     ad;
    logic [CMD_BE_W-1:0] cmd_be;
    logic                parity;
    logic                frame_low;
    logic                initiator_ready_low;
    logic                target_ready_low;
    logic                device_select_low;
    logic                stop_low;
    logic                grant_low;
  } pps_pin_in_t;

  typedef struct packed {
    logic [AD_W-1:0]     ad;
    logic                ad_oe;
    logic [CMD_BE_W-1:0] cmd_be;
    logic                cmd_be_oe;
    logic                parity;
    logic                parity_oe;
    logic                frame_low;
    logic                frame_oe;
    logic                initiator_ready_low;
    logic                initiator_ready_oe;
  } pps_pin_out_t;

  typedef struct packed {
    logic [AD_W-1:0]     addr;
    logic [AD_W-1:0]     addr_hi;
    logic                dual;
    logic [CMD_BE_W-1:0] cmd;
    logic                write;
  } pps_req_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_DATA    = 3'b011,
    ST_GAP     = 3'b100,
    ST_LOAD    = 3'b101,
    ST_ENDING  = 3'b110,
    ST_RELEASE = 3'b111
  } pps_state_t;

  // pin reset: every line floated
  localparam pps_pin_out_t PIN_OUT_RST = '0;
  localparam pps_req_t     REQ_RST     = '0;

  // even parity bit over address/data and command lines
  function automatic logic pps_even_parity(input logic [AD_W-1:0] ad, input logic [CMD_BE_W-1:0] cmd_be);
    pps_even_parity = ^{ad, cmd_be};
  endfunction : pps_even_parity

endpackage : pps_pkg

// file: hdl/pps_sync.sv
// two-stage synchroniser for a vector of pin inputs
// assumes the inputs are asynchronous to i_clk_sys; reset value is a constant parameter
`timescale 1ns/1ps
module pps_sync
  import pps_pkg::*;
#(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             i_clk_sys,  // system clock
  input  wire logic             i_arst_n,   // async reset, active low
  input  wire logic [WIDTH-1:0] i_d,        // asynchronous input
  output logic      [WIDTH-1:0] o_q         // synchronised output
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb begin
    next_meta = i_d;
    next_q    = meta;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= RST_VAL;
      o_q  <= RST_VAL;
    end else begin
      meta <= next_meta;
      o_q  <= next_q;
    end
  end

endmodule : pps_sync

// file: hdl/pps_parity_chk.sv
// receive-side parity checker: samples address/data and command, checks parity a clock later
// assumes inputs are already synchronised to i_clk_sys
`timescale 1ns/1ps
module pps_parity_chk
  import pps_pkg::*;
(
  input  wire logic                i_clk_sys,  // system clock
  input  wire logic                i_arst_n,   // async reset, active low
  input  wire logic                i_sample,   // data received this cycle
  input  wire logic [AD_W-1:0]     i_ad,       // received address/data
  input  wire logic [CMD_BE_W-1:0] i_cmd_be,   // received byte enables
  input  wire logic                i_parity,   // parity line, one clock behind data
  output logic                     o_error     // one-cycle parity error pulse
);

  logic pending;
  logic expected;
  logic next_pending;
  logic next_expected;
  logic next_error;

  always_comb begin
    next_pending  = i_sample;
    next_expected = pps_even_parity(i_ad, i_cmd_be);
    next_error    = pending && (i_parity != expected);
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pending  <= 1'b0;
      expected <= 1'b0;
      o_error  <= 1'b0;
    end else begin
      pending  <= next_pending;
      expected <= next_expected;
      o_error  <= next_error;
    end
  end

endmodule : pps_parity_chk

// file: hdl/pps_primary_pins.sv
// primary bus pin engine: initiator address/data phases, parking, parity, frame and ready release
// assumes pin inputs are asynchronous (synchronised here) and a same-clock core on the user side
`timescale 1ns/1ps

module pps_primary_pins
  import pps_pkg::*;
(
  input  wire logic                i_clk_sys,        // system clock
  input  wire logic                i_arst_n,         // async reset, active low
  input  wire pps_pin_in_t         i_pins,           // primary bus pin levels
  output pps_pin_out_t             o_pins,           // primary bus drive values and enables
  input  wire logic                i_req_valid,      // core requests a transaction
  input  wire pps_req_t            i_req,            // transaction description
  input  wire logic [AD_W-1:0]     i_wr_data,        // write data for the next data phase
  input  wire logic [CMD_BE_W-1:0] i_byte_en_low,    // byte enables, active low
  input  wire logic                i_last_phase,     // next data phase is the final one
  output logic                     o_req_taken,      // request accepted pulse
  output logic                     o_busy,           // transaction in progress
  output logic                     o_phase_done,     // data phase completed pulse
  output logic                     o_rd_valid,       // read data valid pulse
  output logic [AD_W-1:0]          o_rd_data,        // read data
  output logic                     o_master_abort,   // master abort pulse
  output logic                     o_target_stop,    // target stop pulse
  output logic                     o_parity_error    // received parity error pulse
);

  pps_pin_in_t  pin_sync;
  pps_pin_out_t next_pins;
  pps_state_t   state;
  pps_state_t   next_state;
  pps_req_t     req;
  pps_req_t     next_req;
  logic [2:0]   devsel_cnt;
  logic [2:0]   next_devsel_cnt;
  logic         devsel_seen;
  logic         next_devsel_seen;
  logic         last;
  logic         next_last;
  logic         next_req_taken;
  logic         next_busy;
  logic         next_phase_done;
  logic         next_rd_valid;
  logic [AD_W-1:0] next_rd_data;
  logic         next_master_abort;
  logic         next_target_stop;
  logic         bus_idle;
  logic         granted;
  logic         trdy;
  logic         stop;
  logic         devsel;
  logic         rd_sample;

  pps_sync #(
    .WIDTH   ($bits(pps_pin_in_t)),
    .RST_VAL ({$bits(pps_pin_in_t){1'b1}})
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_d       (i_pins),
    .o_q       (pin_sync)
  );

  assign bus_idle  = pin_sync.frame_low && pin_sync.initiator_ready_low;
  assign granted   = !pin_sync.grant_low;
  assign trdy      = !pin_sync.target_ready_low;
  assign stop      = !pin_sync.stop_low;
  assign devsel    = !pin_sync.device_select_low;
  assign rd_sample = (state == ST_DATA) && !req.write && trdy;

  pps_parity_chk u_parity_chk (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_sample  (rd_sample),
    .i_ad      (pin_sync.ad),
    .i_cmd_be  (o_pins.cmd_be),
    .i_parity  (pin_sync.parity),
    .o_error   (o_parity_error)
  );

  always_comb begin
    next_state        = state;
    next_pins         = o_pins;
    next_req          = req;
    next_last         = last;
    next_devsel_cnt   = devsel_cnt;
    next_devsel_seen  = devsel_seen;
    next_req_taken    = 1'b0;
    next_busy         = (state != ST_IDLE);
    next_phase_done   = 1'b0;
    next_rd_valid     = 1'b0;
    next_rd_data      = o_rd_data;
    next_master_abort = 1'b0;
    next_target_stop  = 1'b0;

    // parity follows whatever was on the lines one clock earlier
    next_pins.parity    = pps_even_parity(o_pins.ad, o_pins.cmd_be);
    next_pins.parity_oe = o_pins.ad_oe;

    // device select watchdog from frame assertion
    if (state != ST_IDLE) begin
      if (devsel) begin
        next_devsel_seen = 1'b1;
      end
      if (!devsel_seen && devsel_cnt != DEVSEL_LIMIT) begin
        next_devsel_cnt = devsel_cnt + 3'h1;
      end
    end

    case (state)
      ST_IDLE: begin
        next_pins.frame_oe           = 1'b0;
        next_pins.initiator_ready_oe = 1'b0;
        if (bus_idle && granted) begin
          if (i_req_valid) begin
            next_req             = i_req;
            next_req_taken       = 1'b1;
            next_busy            = 1'b1;
            next_devsel_cnt      = 3'h0;
            next_devsel_seen     = 1'b0;
            next_pins.ad         = i_req.addr;
            next_pins.ad_oe      = 1'b1;
            next_pins.cmd_be     = i_req.dual ? CMD_DUAL_ADDRESS : i_req.cmd;
            next_pins.cmd_be_oe  = 1'b1;
            next_pins.frame_low  = 1'b0;
            next_pins.frame_oe   = 1'b1;
            next_state           = ST_ADDR;
          end else begin
            next_pins.ad         = PARK_AD;
            next_pins.ad_oe      = 1'b1;
            next_pins.cmd_be     = PARK_CMD_BE;
            next_pins.cmd_be_oe  = 1'b1;
          end
        end else begin
          next_pins.ad_oe     = 1'b0;
          next_pins.cmd_be_oe = 1'b0;
        end
      end

      ST_ADDR: begin
        if (req.dual) begin
          next_pins.ad     = req.addr_hi;
          next_pins.cmd_be = req.cmd;
          next_state       = ST_ADDR_HI;
        end else begin
          next_state = ST_LOAD;
        end
      end

      ST_ADDR_HI: begin
        next_state = ST_LOAD;
      end

      ST_LOAD: begin
        next_pins.ad                  = i_wr_data;
        next_pins.ad_oe               = req.write;
        next_pins.cmd_be              = i_byte_en_low;
        next_pins.initiator_ready_low = 1'b0;
        next_pins.initiator_ready_oe  = 1'b1;
        next_pins.frame_low           = i_last_phase;
        next_last                     = i_last_phase;
        next_state                    = ST_DATA;
      end

      ST_DATA: begin
        if (stop) begin
          next_target_stop    = 1'b1;
          next_phase_done     = trdy;
          next_rd_valid       = trdy && !req.write;
          next_rd_data        = trdy ? pin_sync.ad : o_rd_data;
          next_pins.frame_low = 1'b1;
          next_state          = last ? ST_RELEASE : ST_ENDING;
          if (last) begin
            next_pins.frame_oe            = 1'b0;
            next_pins.initiator_ready_low = 1'b1;
            next_pins.ad_oe               = 1'b0;
            next_pins.cmd_be_oe           = 1'b0;
          end
        end else if (trdy) begin
          next_phase_done = 1'b1;
          next_rd_valid   = !req.write;
          next_rd_data    = pin_sync.ad;
          if (last) begin
            next_pins.frame_oe            = 1'b0;
            next_pins.initiator_ready_low = 1'b1;
            next_pins.ad_oe               = 1'b0;
            next_pins.cmd_be_oe           = 1'b0;
            next_state                    = ST_RELEASE;
          end else begin
            next_pins.initiator_ready_low = 1'b1;
            next_state                    = ST_GAP;
          end
        end else if (!devsel_seen && devsel_cnt == DEVSEL_LIMIT) begin
          next_master_abort   = 1'b1;
          next_pins.frame_low = 1'b1;
          next_state          = ST_ENDING;
        end else begin
          next_pins.initiator_ready_low = 1'b0;
        end
      end

      // wait state so the core can present the next word
      ST_GAP: begin
        next_state = ST_LOAD;
      end

      // frame already high; close the phase and release frame
      ST_ENDING: begin
        next_pins.frame_oe            = 1'b0;
        next_pins.initiator_ready_low = 1'b1;
        next_pins.ad_oe               = 1'b0;
        next_pins.cmd_be_oe           = 1'b0;
        next_state                    = ST_RELEASE;
      end

      ST_RELEASE: begin
        next_pins.initiator_ready_oe = 1'b0;
        next_state                   = ST_IDLE;
      end

      default: begin
        next_pins  = PIN_OUT_RST;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state          <= ST_IDLE;
      o_pins         <= PIN_OUT_RST;
      req            <= REQ_RST;
      last           <= 1'b0;
      devsel_cnt     <= 3'h0;
      devsel_seen    <= 1'b0;
      o_req_taken    <= 1'b0;
      o_busy         <= 1'b0;
      o_phase_done   <= 1'b0;
      o_rd_valid     <= 1'b0;
      o_rd_data      <= 32'h0000_0000;
      o_master_abort <= 1'b0;
      o_target_stop  <= 1'b0;
    end else begin
      state          <= next_state;
      o_pins         <= next_pins;
      req            <= next_req;
      last           <= next_last;
      devsel_cnt     <= next_devsel_cnt;
      devsel_seen    <= next_devsel_seen;
      o_req_taken    <= next_req_taken;
      o_busy         <= next_busy;
      o_phase_done   <= next_phase_done;
      o_rd_valid     <= next_rd_valid;
      o_rd_data      <= next_rd_data;
      o_master_abort <= next_master_abort;
      o_target_stop  <= next_target_stop;
    end
  end

endmodule : pps_primary_pins

// file: verif/pps_primary_pins_asserts.sv
// checker for the primary bus pin engine, bound to its top module
// assumes one clock and the asynchronous active-low reset of the design
`timescale 1ns/1ps
module pps_primary_pins_asserts
  import pps_pkg::*;
(
  input wire logic         i_clk_sys,      // clock
  input wire logic         i_arst_n,       // reset
  input wire pps_pin_in_t  i_pins,         // pin levels
  input wire pps_pin_out_t o_pins,         // pin drive
  input wire logic         i_req_valid,    // request
  input wire pps_req_t     i_req,          // request fields
  input wire logic         o_req_taken,    // taken
  input wire logic         o_busy,         // busy
  input wire logic         o_phase_done,   // phase done
  input wire logic         o_rd_valid,     // read word
  input wire logic         o_master_abort, // abort
  input wire logic         o_parity_error  // parity fault
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  chk_frame_release: assert property ($fell(o_pins.frame_oe) |-> $past(o_pins.frame_low))
    else $error("frame floated without high drive");
  chk_irdy_release: assert property ($fell(o_pins.initiator_ready_oe) |-> $past(o_pins.initiator_ready_low))
    else $error("ready floated without high drive");
  chk_par_value: assert property (o_pins.parity_oe |-> o_pins.parity == ^{$past(o_pins.ad), $past(o_pins.cmd_be)})
    else $error("parity not even");
  chk_par_follow: assert property (o_pins.parity_oe == $past(o_pins.ad_oe))
    else $error("parity drive not one clock behind data");
  chk_park_drive: assert property ((!i_pins.grant_low && i_pins.frame_low && i_pins.initiator_ready_low
    && !i_req_valid && !o_busy) [*6] |-> o_pins.ad_oe && o_pins.cmd_be_oe && o_pins.ad == PARK_AD
    && o_pins.cmd_be == PARK_CMD_BE)
    else $error("idle bus not parked");
  chk_req_answer: assert property (o_req_taken |-> !o_pins.frame_low && o_pins.frame_oe && o_pins.ad == i_req.addr
    && o_pins.cmd_be == (i_req.dual ? CMD_DUAL_ADDRESS : i_req.cmd))
    else $error("address phase wrong");
  chk_dual_second: assert property (o_req_taken && i_req.dual |=> o_pins.ad == $past(i_req.addr_hi)
    && o_pins.cmd_be == $past(i_req.cmd))
    else $error("second address phase wrong");
  chk_abort_bound: assert property (o_req_taken |-> ##[0:12] (o_master_abort || !i_pins.device_select_low))
    else $error("no master abort without select");
  chk_read_pair: assert property (o_rd_valid |-> o_phase_done)
    else $error("read word outside a phase");

  cover property (o_req_taken && i_req.dual);
  cover property (o_master_abort);
  cover property (o_parity_error);
endmodule : pps_primary_pins_asserts

bind pps_primary_pins pps_primary_pins_asserts pps_primary_pins_asserts_i (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_pins(i_pins), .o_pins(o_pins),
  .i_req_valid(i_req_valid), .i_req(i_req), .o_req_taken(o_req_taken), .o_busy(o_busy),
  .o_phase_done(o_phase_done), .o_rd_valid(o_rd_valid), .o_master_abort(o_master_abort),
  .o_parity_error(o_parity_error)
);

// file: verif/pps_bus_model.sv
// far-side model of the primary bus: target, grant and pull-ups
// assumes design drive values and enables come from its registers
`timescale 1ns/1ps
module pps_bus_model
  import pps_pkg::*;
(
  input  wire logic            i_clk_sys,   // clock
  input  wire logic            i_arst_n,    // reset
  input  wire pps_pin_out_t    i_drv,       // design drive
  input  wire logic            i_grant,     // grant to design
  input  wire logic            i_devsel_en, // answer as target
  input  wire logic            i_stop_en,   // stop, no ready
  input  wire logic            i_bad_par,   // corrupt read parity
  input  wire logic [AD_W-1:0] i_rd_word,   // read data
  output pps_pin_in_t          o_pins,      // resolved pins
  output logic [AD_W-1:0]      o_last_wr,   // last write word
  output logic [CMD_BE_W-1:0]  o_last_be,   // last byte enables
  output logic [7:0]           o_par_bad    // bad parity seen
);
  logic                dev_act, next_dev_act, m_ad_oe, m_par_oe, par_prev;
  logic [AD_W-1:0]     ad_prev;
  logic [CMD_BE_W-1:0] be_prev;

  always_comb begin
    o_pins = '1;
    o_pins.frame_low = i_drv.frame_oe ? i_drv.frame_low : 1'b1;
    o_pins.initiator_ready_low = i_drv.initiator_ready_oe ? i_drv.initiator_ready_low : 1'b1;
    o_pins.grant_low = !i_grant;
    // target lines end high, then the pull-up holds them
    o_pins.device_select_low = !dev_act;
    o_pins.target_ready_low = !(dev_act && !i_stop_en && !o_pins.initiator_ready_low);
    o_pins.stop_low = !(dev_act && i_stop_en && !o_pins.initiator_ready_low);
    m_ad_oe = dev_act && !i_drv.ad_oe && !o_pins.initiator_ready_low;
    o_pins.ad = i_drv.ad_oe ? i_drv.ad : (m_ad_oe ? i_rd_word : ~ad_prev);
    o_pins.cmd_be = i_drv.cmd_be_oe ? i_drv.cmd_be : ~be_prev;
    o_pins.parity = i_drv.parity_oe ? i_drv.parity :
                    (m_par_oe ? (^{ad_prev, be_prev}) ^ i_bad_par : ~par_prev);
    next_dev_act = i_devsel_en && (!o_pins.frame_low || (dev_act && !o_pins.initiator_ready_low));
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dev_act   <= 1'b0;
      m_par_oe  <= 1'b0;
      ad_prev   <= '0;
      be_prev   <= '0;
      par_prev  <= 1'b0;
      o_last_wr <= '0;
      o_last_be <= '0;
      o_par_bad <= '0;
    end else begin
      dev_act  <= next_dev_act;
      m_par_oe <= m_ad_oe;
      ad_prev  <= o_pins.ad;
      be_prev  <= o_pins.cmd_be;
      par_prev <= o_pins.parity;
      if (i_drv.ad_oe && !o_pins.initiator_ready_low && !o_pins.target_ready_low) begin
        o_last_wr <= i_drv.ad;
        o_last_be <= i_drv.cmd_be;
      end
      if (i_drv.parity_oe && o_pins.parity != ^{ad_prev, be_prev}) o_par_bad <= o_par_bad + 8'h01;
    end
  end
endmodule : pps_bus_model

// file: verif/testbench.sv
// self-checking bench for the primary bus pin engine with a far-side model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module testbench;
  import pps_pkg::*;
  logic                i_clk_sys = 1'b0, i_arst_n = 1'b0, i_req_valid = 1'b0, i_last_phase = 1'b0;
  logic                grant = 1'b0, devsel_en = 1'b1, stop_en = 1'b0, bad_par = 1'b0;
  pps_req_t            i_req = REQ_RST;
  logic [AD_W-1:0]     i_wr_data = '0, rd_word = 32'h5a5a_1234, o_rd_data, last_wr;
  logic [CMD_BE_W-1:0] i_byte_en_low = '0, last_be;
  logic [7:0]          par_bad;
  pps_pin_in_t         i_pins;
  pps_pin_out_t        o_pins;
  logic                o_req_taken, o_busy, o_phase_done, o_rd_valid, o_master_abort, o_target_stop, o_parity_error;
  int                  fail_count = 0, num_checks = 0, phases, aborts, stops, perrs;
  localparam pps_req_t WR = '{addr: 32'h1000_0040, addr_hi: '0, dual: 1'b0, cmd: 4'h7, write: 1'b1};
  localparam pps_req_t RD = '{addr: 32'h2000_0000, addr_hi: 32'h0000_0001, dual: 1'b1, cmd: 4'h6, write: 1'b0};

  always #10 i_clk_sys = ~i_clk_sys;

  pps_primary_pins pps_primary_pins_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_pins(i_pins),
    .o_pins(o_pins), .i_req_valid(i_req_valid), .i_req(i_req), .i_wr_data(i_wr_data),
    .i_byte_en_low(i_byte_en_low), .i_last_phase(i_last_phase), .o_req_taken(o_req_taken), .o_busy(o_busy),
    .o_phase_done(o_phase_done), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_master_abort(o_master_abort), .o_target_stop(o_target_stop), .o_parity_error(o_parity_error));
  pps_bus_model pps_bus_model_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_drv(o_pins), .i_grant(grant),
    .i_devsel_en(devsel_en), .i_stop_en(stop_en), .i_bad_par(bad_par), .i_rd_word(rd_word), .o_pins(i_pins),
    .o_last_wr(last_wr), .o_last_be(last_be), .o_par_bad(par_bad));

  task automatic check_val(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // one transaction of nw data phases; counts its endings
  task automatic do_xfer(input pps_req_t r, input int nw);
    int k;
    int n;
    k = 0;
    n = 0;
    phases = 0;
    aborts = 0;
    stops = 0;
    perrs = 0;
    i_req <= r;
    i_req_valid <= 1'b1;
    i_wr_data <= 32'hc0de_0000;
    i_byte_en_low <= 4'h5;
    i_last_phase <= (nw == 1);
    do @(posedge i_clk_sys); while (o_req_taken !== 1'b1 && ++n < 20);
    i_req_valid <= 1'b0;
    for (n = 0; n < 100 && (o_busy === 1'b1 || n < 3); n++) begin
      @(posedge i_clk_sys);
      if (o_master_abort === 1'b1) aborts++;
      if (o_target_stop === 1'b1) stops++;
      if (o_parity_error === 1'b1) perrs++;
      if (o_rd_valid === 1'b1) check_val(o_rd_data, rd_word);
      if (o_phase_done === 1'b1) begin
        if (r.write) check_val(last_wr, 32'(32'hc0de_0000 + k));
        if (r.write) check_val(last_be, 4'h5 ^ k[3:0]);
        k++;
        phases++;
        i_wr_data <= 32'(32'hc0de_0000 + k);
        i_byte_en_low <= 4'h5 ^ k[3:0];
        i_last_phase <= (k == nw - 1);
      end
    end
  endtask : do_xfer

  task automatic test_park();
    repeat (6) @(posedge i_clk_sys);
    check_val(o_pins.ad_oe, 1'b0);
    grant <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    check_val({o_pins.ad_oe, o_pins.cmd_be_oe, o_pins.parity_oe}, 3'h7);
    check_val(o_pins.ad, PARK_AD);
    check_val(o_pins.cmd_be, PARK_CMD_BE);
    check_val(o_pins.parity, ^{PARK_AD, PARK_CMD_BE});
  endtask : test_park

  task automatic test_write();
    do_xfer(WR, 3);
    check_val(phases, 3);
    check_val(par_bad, 8'h00);
    check_val({o_pins.frame_oe, i_pins.frame_low}, 2'h1);
  endtask : test_write

  task automatic test_dual_read();
    do_xfer(RD, 2);
    check_val(phases, 2);
    check_val(perrs, 0);
  endtask : test_dual_read

  task automatic test_bad_parity();
    bad_par <= 1'b1;
    do_xfer(RD, 1);
    bad_par <= 1'b0;
    check_val(perrs, 1);
  endtask : test_bad_parity

  task automatic test_abort();
    devsel_en <= 1'b0;
    do_xfer(WR, 1);
    devsel_en <= 1'b1;
    check_val(aborts, 1);
    check_val(phases, 0);
  endtask : test_abort

  task automatic test_stop();
    stop_en <= 1'b1;
    do_xfer(RD, 2);
    stop_en <= 1'b0;
    check_val(stops, 1);
    check_val(phases, 0);
  endtask : test_stop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    test_park();
    test_write();
    test_dual_read();
    test_bad_parity();
    test_abort();
    test_stop();
    end_of_test();
  end

  initial begin
    repeat (4000) @(posedge i_clk_sys);
    fail_count++;
    end_of_test();
  end
endmodule : testbench
